/* apc_audio_host.sv */
`timescale 1ns/1ps
module apc_audio_host (
    // Clock and control
    input wire logic pclk,
    input wire logic run,
    input wire logic [9:0] ratio,
    // Serial audio clocks
    output logic master_clock,
    output logic bit_clock,
    output logic frame_clock
);
    logic [9:0] cnt_q;

    // Clocks stand still while idle, as a real host does between streams
    always_ff @(posedge pclk) begin
        if (!run) begin
            cnt_q <= 10'h000;
            master_clock <= 1'b0;
            bit_clock <= 1'b0;
            frame_clock <= 1'b0;
        end else begin
            master_clock <= ~master_clock;
            // One master clock rising edge per count; ratio edges per frame
            if (master_clock) begin
                cnt_q <= (cnt_q >= ratio - 10'h001) ? 10'h000 : cnt_q + 10'h001;
            end
            frame_clock <= (cnt_q < (ratio >> 1));
            bit_clock <= cnt_q[1];
        end
    end
endmodule : apc_audio_host

/* apc_clock_config.sv */
// Our own choice: register access over APB.
`timescale 1ns/1ps
module apc_clock_config #(
    parameter logic [11:0] TIMEOUT_CYC = apc_pkg::APC_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial audio clocks, sampled
    input wire logic master_clock,
    input wire logic bit_clock_i,
    input wire logic frame_clock_i,
    // Master mode pin drive
    output logic bit_clock_o,
    output logic bit_clock_oe,
    output logic frame_clock_o,
    output logic frame_clock_oe,
    // Clock tree control
    output apc_pkg::apc_pll_cfg_t pll_cfg,
    output logic pll_bypass,
    output logic [19:0] pll_k,
    output apc_pkg::apc_clk_div_t clk_div,
    output logic clocks_valid,
    output logic clock_error
);
    import apc_pkg::*;

    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    logic [7:0] regs_q [APC_NREG];
    logic [4:0] slot_hit;
    logic page_ok, map_ok, wr;
    logic [31:0] rd_d;
    logic auto_en, ign_err, master;

    assign slot_hit = apc_slot(paddr[9:2]);
    assign page_ok = paddr[11:10] == 2'h0;
    assign map_ok = page_ok && (slot_hit[4] || paddr[9:2] == APC_IDX_STAT);
    assign wr = psel && penable && pready_q && pwrite;
    assign auto_en = regs_q[APC_S_AUTO][APC_AUTO_BIT];
    assign ign_err = regs_q[APC_S_AUTO][APC_IGN_BIT];
    assign master = regs_q[APC_S_AUTO][APC_MSTR_BIT];

    // Zero-wait slave: ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= psel && !penable;
            pslverr_q <= psel && !penable && !map_ok;
            if (psel && !penable && !pwrite) begin
                prdata_q <= rd_d;
            end
        end
    end

    // Register file; masked write keeps unused bits at zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < APC_NREG; i++) begin
                regs_q[i] <= APC_RST[i];
            end
        end else if (wr && page_ok && slot_hit[4]) begin
            regs_q[slot_hit[3:0]] <= pwdata[7:0] & APC_MASK[slot_hit[3:0]];
        end
    end

    // Clock detector
    logic mclk_q, bclk_q, fclk_q, f_edge;
    logic [11:0] per_cnt_q;
    logic [9:0] mcnt_q;
    logic bseen_q, armed_q, valid_q;
    logic [2:0] ratio_q;
    apc_rate_t rate_q, rate_d;

    assign f_edge = frame_clock_i && !fclk_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mclk_q <= 1'b0;
            bclk_q <= 1'b0;
            fclk_q <= 1'b0;
        end else begin
            mclk_q <= master_clock;
            bclk_q <= bit_clock_i;
            fclk_q <= frame_clock_i;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_cnt_q <= 12'h0;
            mcnt_q <= 10'h0;
            bseen_q <= 1'b0;
        end else if (f_edge) begin
            per_cnt_q <= 12'h0;
            // An edge on the frame edge opens the new frame, else one is lost per frame
            mcnt_q <= {9'h0, master_clock && !mclk_q};
            bseen_q <= bit_clock_i && !bclk_q;
        end else begin
            if (per_cnt_q != TIMEOUT_CYC) begin
                per_cnt_q <= per_cnt_q + 12'h1;
            end
            if (master_clock && !mclk_q && mcnt_q != 10'h3ff) begin
                mcnt_q <= mcnt_q + 10'h1;
            end
            if (bit_clock_i && !bclk_q) begin
                bseen_q <= 1'b1;
            end
        end
    end

    // Frame period to rate class
    always_comb begin
        if (per_cnt_q > APC_TH_8K) begin
            rate_d = APC_R8K;
        end else if (per_cnt_q > APC_TH_16K) begin
            rate_d = APC_R16K;
        end else if (per_cnt_q > APC_TH_32K) begin
            rate_d = APC_R32K;
        end else if (per_cnt_q > APC_TH_SGL) begin
            rate_d = APC_RSGL;
        end else begin
            rate_d = APC_RDBL;
        end
    end

    // First edge only arms: the period before it is partial
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_q <= 1'b0;
            valid_q <= 1'b0;
            ratio_q <= APC_RATIO_BAD;
            rate_q <= APC_RSGL;
        end else if (f_edge) begin
            armed_q <= 1'b1;
            ratio_q <= apc_ratio_code(mcnt_q);
            rate_q <= rate_d;
            valid_q <= armed_q && bseen_q && per_cnt_q >= APC_PER_MIN
                && per_cnt_q != TIMEOUT_CYC
                && apc_ratio_code(mcnt_q) != APC_RATIO_BAD;
        end else if (per_cnt_q == TIMEOUT_CYC) begin
            armed_q <= 1'b0;
            valid_q <= 1'b0;
        end
    end

    // Automatic and manual settings
    apc_pll_cfg_t auto_cfg, man_cfg;
    logic [13:0] auto_n, d_raw;

    always_comb begin
        auto_cfg = APC_CFG_RST;
        auto_cfg.ref_sel = APC_REF_MCLK;
        auto_n = APC_N_STD;
        unique case (ratio_q)
            3'h0: auto_cfg.j = 6'h20;
            3'h1: auto_cfg.j = 6'h10;
            3'h2: begin
                auto_cfg.j = 6'h0a;
                auto_cfg.d = 14'h1a0b;
            end
            3'h3: auto_cfg.j = 6'h08;
            3'h4: begin
                auto_cfg.j = 6'h05;
                auto_cfg.d = 14'h0d05;
            end
            default: auto_cfg.j = 6'h04;
        endcase
        // Scale N so the VCO stays in range at each rate
        unique case (rate_q)
            APC_R8K: begin
                auto_cfg.r_code = 4'h5;
                auto_n = APC_N_8K;
            end
            APC_R16K: begin
                auto_cfg.r_code = 4'h2;
                auto_n = APC_N_16K;
            end
            APC_R32K, APC_RSGL: auto_n = APC_N_STD;
            APC_RDBL: begin
                auto_cfg.p_code = 4'h2;
                auto_n = APC_N_DBL;
            end
        endcase
    end

    always_comb begin
        d_raw = {regs_q[APC_S_DH][5:0], regs_q[APC_S_DL]};
        man_cfg.on = regs_q[APC_S_ON][APC_ON_BIT];
        man_cfg.ref_sel = regs_q[APC_S_REF][6:4];
        man_cfg.p_code = regs_q[APC_S_P][3:0] == 4'h0 ? 4'h1 : regs_q[APC_S_P][3:0];
        man_cfg.j = regs_q[APC_S_J][5:0];
        man_cfg.d = d_raw > APC_D_MAX ? APC_D_MAX : d_raw;
        man_cfg.r_code = regs_q[APC_S_R][3:0];
    end

    // Auto mode holds the last good setting while clocks are lost
    apc_pll_cfg_t pll_cfg_q;
    logic pll_bypass_q;
    logic [19:0] pll_k_q;
    apc_clk_div_t clk_div_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_cfg_q <= APC_CFG_RST;
            pll_bypass_q <= 1'b0;
            clk_div_q <= '0;
        end else begin
            if (auto_en) begin
                if (valid_q) begin
                    pll_cfg_q <= auto_cfg;
                    pll_bypass_q <= 1'b0;
                    clk_div_q.pll_fs <= auto_n;
                    clk_div_q.osr_div <= auto_n[13:6] >> 2;
                    clk_div_q.filt_div <= auto_n[13:10];
                end
            end else begin
                pll_cfg_q <= man_cfg;
                pll_bypass_q <= !man_cfg.on;
                clk_div_q.pll_fs <= APC_N_STD;
                clk_div_q.osr_div <= APC_N_STD[13:6] >> 2;
                clk_div_q.filt_div <= APC_N_STD[13:10];
            end
            clk_div_q.ncp_div <= APC_NCP_DIV;
            clk_div_q.dsp_div <= regs_q[APC_S_DSP][6:0];
            clk_div_q.bclk_div <= regs_q[APC_S_BCLK][6:0];
            clk_div_q.fclk_div <= regs_q[APC_S_FCLK];
        end
    end

    // Multiplier for the analog loop: output = ref * R * K / P
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_k_q <= 20'h0;
        end else begin
            pll_k_q <= 20'(pll_cfg_q.j) * APC_K_SCALE + 20'(pll_cfg_q.d);
        end
    end

    // Master mode: bit clock from pclk, frame clock from bit clock
    logic [6:0] bcnt_q;
    logic [7:0] fcnt_q, fnext;
    logic bclk_o_q, fclk_o_q, oe_q;

    assign fnext = fcnt_q == clk_div_q.fclk_div ? 8'h0 : fcnt_q + 8'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bcnt_q <= 7'h0;
            fcnt_q <= 8'h0;
            bclk_o_q <= 1'b0;
            fclk_o_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            oe_q <= master;
            if (!master) begin
                bcnt_q <= 7'h0;
                fcnt_q <= 8'h0;
                bclk_o_q <= 1'b0;
                fclk_o_q <= 1'b0;
            end else if (bcnt_q == clk_div_q.bclk_div) begin
                bcnt_q <= 7'h0;
                bclk_o_q <= !bclk_o_q;
                if (!bclk_o_q) begin
                    fcnt_q <= fnext;
                    fclk_o_q <= fnext <= (clk_div_q.fclk_div >> 1);
                end
            end else begin
                bcnt_q <= bcnt_q + 7'h1;
            end
        end
    end

    logic cfg_bad_q, clocks_valid_q, clock_error_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_bad_q <= 1'b0;
            clocks_valid_q <= 1'b0;
            clock_error_q <= 1'b0;
        end else begin
            cfg_bad_q <= pll_cfg_q.d != 14'h0 && pll_cfg_q.r_code != 4'h0;
            clocks_valid_q <= valid_q;
            clock_error_q <= !valid_q && !ign_err;
        end
    end

    always_comb begin
        rd_d = 32'h0;
        if (page_ok && paddr[9:2] == APC_IDX_STAT) begin
            rd_d = {20'h0, cfg_bad_q, 3'(rate_q), 3'h0, ratio_q, clock_error_q, valid_q};
        end else if (page_ok && slot_hit[4]) begin
            rd_d = {24'h0, regs_q[slot_hit[3:0]]};
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign bit_clock_o = bclk_o_q;
    assign frame_clock_o = fclk_o_q;
    assign bit_clock_oe = oe_q;
    assign frame_clock_oe = oe_q;
    assign pll_cfg = pll_cfg_q;
    assign pll_bypass = pll_bypass_q;
    assign pll_k = pll_k_q;
    assign clk_div = clk_div_q;
    assign clocks_valid = clocks_valid_q;
    assign clock_error = clock_error_q;

    // Checks
    logic on_wr_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_wr_q <= 1'b0;
        end else if (wr && slot_hit == {1'b1, APC_S_ON}) begin
            on_wr_q <= 1'b1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_auto_cfg;
        auto_en && valid_q |=> pll_cfg_q.on && pll_cfg_q.ref_sel == APC_REF_MCLK;
    endproperty
    a_auto_cfg: assert property (p_auto_cfg) else $error("auto setup missed");

    property p_rate_div;
        auto_en && valid_q && rate_q == APC_R8K |=>
            clk_div_q.pll_fs == APC_N_8K && clk_div_q.osr_div == 8'(APC_N_8K >> 8);
    endproperty
    a_rate_div: assert property (p_rate_div) else $error("rate dividers wrong");

    property p_ref_sel;
        !auto_en && wr && paddr == {2'h0, APC_IDX_REF, 2'h0} |=>
            ##1 pll_cfg_q.ref_sel == $past(pwdata[6:4], 2);
    endproperty
    a_ref_sel: assert property (p_ref_sel) else $error("reference select lost");

    property p_bypass;
        !auto_en && wr && paddr == {2'h0, APC_IDX_ON, 2'h0} && !pwdata[0] |=> ##1 pll_bypass_q;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not taken");

    property p_reset_on;
        !on_wr_q |-> !pll_bypass_q && regs_q[APC_S_ON][APC_ON_BIT];
    endproperty
    a_reset_on: assert property (p_reset_on) else $error("pll off without write");

    property p_k;
        presetn |=> pll_k_q == 20'($past(pll_cfg_q.j)) * APC_K_SCALE + 20'($past(pll_cfg_q.d));
    endproperty
    a_k: assert property (p_k) else $error("multiplier wrong");

    property p_ranges;
        pll_cfg_q.d <= APC_D_MAX && pll_cfg_q.p_code != 4'h0;
    endproperty
    a_ranges: assert property (p_ranges) else $error("coefficient out of range");

    property p_mask;
        wr && slot_hit == {1'b1, APC_S_J} |=> regs_q[APC_S_J][7:6] == 2'h0;
    endproperty
    a_mask: assert property (p_mask) else $error("unused bits stored");

    property p_timeout;
        per_cnt_q == TIMEOUT_CYC && !f_edge |=> !valid_q;
    endproperty
    a_timeout: assert property (p_timeout) else $error("lost clocks kept valid");

    property p_ratio;
        f_edge && apc_ratio_code(mcnt_q) == APC_RATIO_BAD |=> !valid_q;
    endproperty
    a_ratio: assert property (p_ratio) else $error("bad ratio accepted");

    property p_master;
        master && oe_q && bcnt_q == clk_div_q.bclk_div |=> bclk_o_q != $past(bclk_o_q);
    endproperty
    a_master: assert property (p_master) else $error("bit clock stalled");

    property p_div;
        wr && paddr == {2'h0, APC_IDX_BCLK, 2'h0} |=> ##1 clk_div_q.bclk_div == $past(pwdata[6:0], 2);
    endproperty
    a_div: assert property (p_div) else $error("bit clock divider lost");

    c_auto: cover property (auto_en && valid_q ##1 clocks_valid_q);
    c_bypass: cover property (!auto_en && pll_bypass_q);
    c_master: cover property (oe_q && fclk_o_q);
    c_err: cover property (clock_error_q ##1 !clock_error_q);
endmodule : apc_clock_config

/* apc_pkg.sv */
package apc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] APC_IDX_ON = 8'h04;
    localparam logic [7:0] APC_IDX_REF = 8'h0d;
    localparam logic [7:0] APC_IDX_P = 8'h14;
    localparam logic [7:0] APC_IDX_J = 8'h15;
    localparam logic [7:0] APC_IDX_DH = 8'h16;
    localparam logic [7:0] APC_IDX_DL = 8'h17;
    localparam logic [7:0] APC_IDX_R = 8'h18;
    localparam logic [7:0] APC_IDX_DSP = 8'h1b;
    localparam logic [7:0] APC_IDX_BCLK = 8'h20;
    localparam logic [7:0] APC_IDX_FCLK = 8'h21;
    localparam logic [7:0] APC_IDX_AUTO = 8'h25;
    localparam logic [7:0] APC_IDX_STAT = 8'h26;
    localparam int APC_NREG = 11;
    localparam logic [3:0] APC_S_ON = 4'h0;
    localparam logic [3:0] APC_S_REF = 4'h1;
    localparam logic [3:0] APC_S_P = 4'h2;
    localparam logic [3:0] APC_S_J = 4'h3;
    localparam logic [3:0] APC_S_DH = 4'h4;
    localparam logic [3:0] APC_S_DL = 4'h5;
    localparam logic [3:0] APC_S_R = 4'h6;
    localparam logic [3:0] APC_S_DSP = 4'h7;
    localparam logic [3:0] APC_S_BCLK = 4'h8;
    localparam logic [3:0] APC_S_FCLK = 4'h9;
    localparam logic [3:0] APC_S_AUTO = 4'ha;
    // Writable bits per slot, and values after reset
    localparam logic [7:0] APC_MASK [APC_NREG] = '{8'h01, 8'h70, 8'h0f, 8'h3f, 8'h3f,
        8'hff, 8'h0f, 8'h7f, 8'h7f, 8'hff, 8'h07};
    localparam logic [7:0] APC_RST [APC_NREG] = '{8'h01, 8'h00, 8'h01, 8'h08, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
    localparam int APC_ON_BIT = 0;
    localparam int APC_AUTO_BIT = 0;
    localparam int APC_IGN_BIT = 1;
    localparam int APC_MSTR_BIT = 2;
    localparam logic [2:0] APC_REF_MCLK = 3'h0;
    localparam logic [2:0] APC_REF_BCLK = 3'h1;
    localparam logic [2:0] APC_REF_GPIO = 3'h3;
    localparam logic [13:0] APC_D_MAX = 14'h270f;
    localparam logic [19:0] APC_K_SCALE = 20'h02710;
    localparam logic [13:0] APC_N_8K = 14'h3000;
    localparam logic [13:0] APC_N_16K = 14'h1800;
    localparam logic [13:0] APC_N_STD = 14'h0800;
    localparam logic [13:0] APC_N_DBL = 14'h0400;
    localparam logic [2:0] APC_NCP_DIV = 3'h4;
    localparam logic [2:0] APC_RATIO_BAD = 3'h7;
    // Frame period bounds in pclk cycles
    localparam int APC_CLK_NS = 40;
    localparam int APC_TIMEOUT_NS = 150000;
    localparam logic [11:0] APC_TIMEOUT_CYC = 12'(APC_TIMEOUT_NS / APC_CLK_NS);
    localparam logic [11:0] APC_TH_8K = 12'h8fc;
    localparam logic [11:0] APC_TH_16K = 12'h44c;
    localparam logic [11:0] APC_TH_32K = 12'h28a;
    localparam logic [11:0] APC_TH_SGL = 12'h17c;
    localparam logic [11:0] APC_PER_MIN = 12'h0c8;

    typedef enum logic [2:0] {APC_R8K, APC_R16K, APC_R32K, APC_RSGL, APC_RDBL} apc_rate_t;

    typedef struct packed {
        logic on;
        logic [2:0] ref_sel;
        logic [3:0] p_code;
        logic [5:0] j;
        logic [13:0] d;
        logic [3:0] r_code;
    } apc_pll_cfg_t;

    typedef struct packed {
        logic [13:0] pll_fs;
        logic [7:0] osr_div;
        logic [3:0] filt_div;
        logic [2:0] ncp_div;
        logic [6:0] dsp_div;
        logic [6:0] bclk_div;
        logic [7:0] fclk_div;
    } apc_clk_div_t;

    localparam apc_pll_cfg_t APC_CFG_RST = '{1'b1, 3'h0, 4'h1, 6'h08, 14'h0000, 4'h0};

    // Returns {hit, slot}
    function automatic logic [4:0] apc_slot(input logic [7:0] idx);
        unique case (idx)
            APC_IDX_ON: return {1'b1, APC_S_ON};
            APC_IDX_REF: return {1'b1, APC_S_REF};
            APC_IDX_P: return {1'b1, APC_S_P};
            APC_IDX_J: return {1'b1, APC_S_J};
            APC_IDX_DH: return {1'b1, APC_S_DH};
            APC_IDX_DL: return {1'b1, APC_S_DL};
            APC_IDX_R: return {1'b1, APC_S_R};
            APC_IDX_DSP: return {1'b1, APC_S_DSP};
            APC_IDX_BCLK: return {1'b1, APC_S_BCLK};
            APC_IDX_FCLK: return {1'b1, APC_S_FCLK};
            APC_IDX_AUTO: return {1'b1, APC_S_AUTO};
            default: return 5'h00;
        endcase
    endfunction : apc_slot

    // Master clock edges per frame to ratio code
    function automatic logic [2:0] apc_ratio_code(input logic [9:0] n);
        unique case (n)
            10'h040: return 3'h0;
            10'h080: return 3'h1;
            10'h0c0: return 3'h2;
            10'h100: return 3'h3;
            10'h180: return 3'h4;
            10'h200: return 3'h5;
            default: return APC_RATIO_BAD;
        endcase
    endfunction : apc_ratio_code
endpackage : apc_pkg

/* audio_pll_clock_config_tb.sv */
`timescale 1ns/1ps
module audio_pll_clock_config_tb;
    import apc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, bck_o, bck_oe, fck_o, fck_oe, pll_bypass, clocks_valid, clock_error;
    logic mclk, bclk, fclk, run = 1'b0, err;
    logic [9:0] ratio = 10'h100;
    logic [7:0] rd;
    logic [19:0] pll_k;
    apc_pll_cfg_t pll_cfg;
    apc_clk_div_t clk_div;
    int failures = 0, compares = 0;
    localparam logic [7:0] IDX [APC_NREG] = '{APC_IDX_ON, APC_IDX_REF, APC_IDX_P, APC_IDX_J,
        APC_IDX_DH, APC_IDX_DL, APC_IDX_R, APC_IDX_DSP, APC_IDX_BCLK, APC_IDX_FCLK, APC_IDX_AUTO};

    always #20 pclk = ~pclk;

    apc_clock_config #(.TIMEOUT_CYC(12'h3e8)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .master_clock(mclk),
        .bit_clock_i(bclk), .frame_clock_i(fclk), .bit_clock_o(bck_o), .bit_clock_oe(bck_oe),
        .frame_clock_o(fck_o), .frame_clock_oe(fck_oe), .pll_cfg(pll_cfg),
        .pll_bypass(pll_bypass), .pll_k(pll_k), .clk_div(clk_div),
        .clocks_valid(clocks_valid), .clock_error(clock_error));

    apc_audio_host host (.pclk(pclk), .run(run), .ratio(ratio), .master_clock(mclk),
        .bit_clock(bclk), .frame_clock(fclk));

    task automatic end_of_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            failures++;
            end_of_test();
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic t_reset();
        for (int i = 0; i < APC_NREG; i++) begin
            apb(1'b0, IDX[i], 8'h00);
            chk("reset value", {24'h0, APC_RST[i]}, {24'h0, rd});
        end
        chk("cfg after reset", APC_CFG_RST, pll_cfg);
        chk("bypass after reset", 1'b0, pll_bypass);
        apb(1'b0, 8'h30, 8'h00);
        chk("unmapped error", 1'b1, err);
        $display("test reset done");
    endtask : t_reset

    task automatic t_mask();
        for (int i = 0; i < APC_NREG - 1; i++) begin
            apb(1'b1, IDX[i], 8'hff);
            apb(1'b0, IDX[i], 8'h00);
            chk("field mask", {24'h0, APC_MASK[i]}, {24'h0, rd});
            apb(1'b1, IDX[i], APC_RST[i]);
        end
        $display("test mask done");
    endtask : t_mask

    task automatic t_manual();
        logic [2:0] rs [3] = '{APC_REF_MCLK, APC_REF_BCLK, APC_REF_GPIO};
        apb(1'b1, APC_IDX_AUTO, 8'h00);
        apb(1'b1, APC_IDX_P, 8'h03);
        apb(1'b1, APC_IDX_J, 8'h07);
        apb(1'b1, APC_IDX_DH, 8'h14);
        apb(1'b1, APC_IDX_DL, 8'h90);
        apb(1'b1, APC_IDX_R, 8'h00);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, APC_IDX_REF, {1'b0, rs[i], 4'h0});
            repeat (3) @(posedge pclk);
            chk("ref select", rs[i], pll_cfg.ref_sel);
        end
        chk("manual p j d r", {4'h3, 6'h07, 14'h1490, 4'h0},
            {pll_cfg.p_code, pll_cfg.j, pll_cfg.d, pll_cfg.r_code});
        chk("manual k", 20'h12600, pll_k);
        apb(1'b1, APC_IDX_DH, 8'h00);
        apb(1'b1, APC_IDX_DL, 8'h00);
        repeat (3) @(posedge pclk);
        chk("integer k", 20'h11170, pll_k);
        apb(1'b1, APC_IDX_ON, 8'h00);
        repeat (3) @(posedge pclk);
        chk("pll off bypass", 2'b01, {pll_cfg.on, pll_bypass});
        apb(1'b1, APC_IDX_ON, 8'h01);
        $display("test manual done");
    endtask : t_manual

    task automatic t_auto();
        int n;
        apb(1'b1, APC_IDX_AUTO, 8'h01);
        run <= 1'b1;
        for (n = 0; n < 4000 && pll_k !== 20'h13880; n++) @(posedge pclk);
        chk("auto k 256", 20'h13880, pll_k);
        chk("auto valid", 1'b1, clocks_valid);
        chk("auto p j d r", {4'h1, 6'h08, 14'h0000, 4'h0},
            {pll_cfg.p_code, pll_cfg.j, pll_cfg.d, pll_cfg.r_code});
        chk("auto dividers", {APC_N_STD, 8'h08, 4'h2, APC_NCP_DIV},
            {clk_div.pll_fs, clk_div.osr_div, clk_div.filt_div, clk_div.ncp_div});
        ratio <= 10'h0c0;
        for (n = 0; n < 4000 && pll_k !== 20'h1a0ab; n++) @(posedge pclk);
        chk("auto k 192", 20'h1a0ab, pll_k);
        chk("auto j d 192", {6'h0a, 14'h1a0b}, {pll_cfg.j, pll_cfg.d});
        ratio <= 10'h064;
        for (n = 0; n < 4000 && clocks_valid !== 1'b0; n++) @(posedge pclk);
        chk("odd ratio valid error", 2'b01, {clocks_valid, clock_error});
        apb(1'b1, APC_IDX_AUTO, 8'h03);
        repeat (3) @(posedge pclk);
        chk("ignored error", 1'b0, clock_error);
        run <= 1'b0;
        $display("test auto done");
    endtask : t_auto

    task automatic t_master();
        int n;
        apb(1'b1, APC_IDX_AUTO, 8'h04);
        repeat (3) @(posedge pclk);
        chk("master enables", 2'b11, {bck_oe, fck_oe});
        for (n = 0; n < 400 && bck_o !== 1'b1; n++) @(posedge pclk);
        chk("master bit clock", 1'b1, bck_o);
        apb(1'b1, APC_IDX_AUTO, 8'h00);
        repeat (3) @(posedge pclk);
        chk("slave enables", 2'b00, {bck_oe, fck_oe});
        $display("test master done");
    endtask : t_master

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_mask();
        t_manual();
        t_auto();
        t_master();
        end_of_test();
    end
endmodule : audio_pll_clock_config_tb
